//--- src/dwg_pkg.sv
// Purpose: Constants for the per-channel waveform generator.
// Assumes: 125 MHz reference clock, 12-bit channel codes.
// Notes: Register map is local to this block; offsets are word indices.
// Behaviour
// - Every channel makes its own continuous waveform from its own setup, margins, step and slew.
// - Triangle mode ramps the code up from the low margin to the high margin and back down, repeatedly.
// - The triangle period is twice the step time times (high minus low plus one) over the code step.
// - Function code 000 selects the triangle.
// - Sawtooth and inverse sawtooth step the code across the range from the low to the high margin.
// - The sawtooth period is the step time times (high minus low plus one) over the code step.
// - Function code 001 selects a rising sawtooth and 010 a falling one.
// - Sine mode gives 24 fixed points per cycle, one point per step.
// - The sine frequency is one over 24 step times, whatever the margins and code step.
// - Function code 100 selects the sine.
// - Sine codes come from a fixed 12-bit table, 0x800 at points 0 and 12, 0xe66 at 6 and 0x19a at 18.
// - Sine codes cannot be changed by software; amplitude comes only from the output gain setting.
// - Each channel offers four selectable sine starting phases from a field in its setup register.
// - Code step, slew and function select of a channel sit together in its setup register.
// - The slew field is 4 bits; 0 means no slew, 1 gives 4 us per step, up to 5127.92 us at 15.
package dwg_pkg;
  localparam int DW = 12;
  localparam int AW = 4;
  localparam int RW = 16;
  // Register indices per channel: base = ch * CH_STRIDE
  localparam logic [AW-1:0] REG_SETUP = 4'h0;
  localparam logic [AW-1:0] REG_MLOW = 4'h1;
  localparam logic [AW-1:0] REG_MHIGH = 4'h2;
  localparam logic [AW-1:0] REG_OUTSET = 4'h3;
  localparam logic [AW-1:0] REG_CODE = 4'h4;
  localparam int CH_STRIDE = 8;
  // Setup register fields, then the gain field of the output setting register
  localparam int F_SLEW_LSB = 0;
  localparam int F_STEP_LSB = 4;
  localparam int F_FUNC_LSB = 8;
  localparam int F_PHASE_LSB = 11;
  localparam int F_START_BIT = 13;
  localparam int F_GAIN_LSB = 0;
  localparam logic [RW-1:0] SETUP_RST = 16'h0000;
  localparam logic [RW-1:0] MLOW_RST = 16'h0000;
  localparam logic [RW-1:0] MHIGH_RST = 16'h0fff;
  localparam logic [2:0] FN_TRI = 3'h0;
  localparam logic [2:0] FN_SAW = 3'h1;
  localparam logic [2:0] FN_ISAW = 3'h2;
  localparam logic [2:0] FN_SINE = 3'h4;
  localparam int SINE_PTS = 24;
  localparam logic [4:0] SINE_LAST = 5'h17;
  localparam logic [4:0] PHASE_PTS = 5'h06;
  localparam int CLK_MHZ = 125;
  // Step times in ns, as printed (hundredths of us kept exact in ns)
  localparam int STEP_NS [16] = '{0, 4000, 8000, 12000, 18000, 27000, 40500, 60750, 91130,
                                  136690, 239200, 418610, 732560, 1281980, 2563960, 5127920};
  localparam int TW = 20;
  function automatic logic [TW-1:0] step_cycles(input logic [3:0] code);
    int c;
    c = STEP_NS[code] * CLK_MHZ / 1000;
    if (c < 1)
      c = 1;
    return TW'(c);
  endfunction
  function automatic logic [DW-1:0] code_step_lsb(input logic [2:0] sel);
    case (sel)
      3'h0: return 12'h001;
      3'h1: return 12'h002;
      3'h2: return 12'h003;
      3'h3: return 12'h004;
      3'h4: return 12'h006;
      3'h5: return 12'h008;
      3'h6: return 12'h010;
      default: return 12'h020;
    endcase
  endfunction
  typedef enum logic [1:0] {
    DWG_IDLE = 2'b00,
    DWG_UP = 2'b01,
    DWG_DOWN = 2'b10
  } dwg_dir_e;
endpackage

//--- src/dwg_sine_rom.sv
// Purpose: Fixed 24-point 12-bit sine table with registered read data.
// Assumes: Index below 24; other indices read mid-scale.
// Notes: Table is constant; software has no write path to it.
`timescale 1ns/1ps
module dwg_sine_rom (
  input wire logic ref_clk_i, // Clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [4:0] idx_i, // Point index
  output logic [11:0] data_o // Registered sine code
);
  function automatic logic [11:0] quarter(input logic [2:0] k);
    case (k)
      3'h0: return 12'h800;
      3'h1: return 12'h9a8;
      3'h2: return 12'hb33;
      3'h3: return 12'hc87;
      3'h4: return 12'hd8b;
      3'h5: return 12'he2f;
      default: return 12'he66;
    endcase
  endfunction
  logic [4:0] half_idx;
  logic [2:0] k;
  logic [11:0] mag;
  always_comb
  begin
    half_idx = (idx_i >= 5'd12) ? idx_i - 5'd12 : idx_i;
    k = (half_idx > 5'd6) ? 3'(5'd12 - half_idx) : half_idx[2:0];
    mag = quarter(k);
  end
  // Lower half mirrors upper about 0x800
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      data_o <= 12'h800;
    else if (idx_i >= 5'd24)
      data_o <= 12'h800;
    else if (idx_i >= 5'd12)
      data_o <= 12'h000 - mag;
    else
      data_o <= mag;
  end
endmodule

//--- src/dwg_top.sv
// Purpose: Multi-channel waveform generator driving DAC channel codes.
// Assumes: Plain register port, read data valid the cycle after the strobe.
// Notes: Slew 0 stops stepping; the code holds its restart value (low margin, high margin for inverse sawtooth, phase point for sine).
`timescale 1ns/1ps
module dwg_top #(
  parameter int NCH = 2
) (
  input wire logic ref_clk_i, // 125 MHz clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [dwg_pkg::AW-1:0] addr_i, // Register word index
  input wire logic [dwg_pkg::RW-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [dwg_pkg::RW-1:0] rdata_o, // Read data, one cycle later
  output logic [NCH*dwg_pkg::DW-1:0] code_o, // Channel codes
  output logic [NCH*3-1:0] gain_o // Channel amplifier gain
);
  logic [dwg_pkg::RW-1:0] rd_mux;
  logic [dwg_pkg::RW-1:0] ch_rd [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : gen_ch
      logic [dwg_pkg::RW-1:0] setup_q;
      logic [dwg_pkg::DW-1:0] mlow_q;
      logic [dwg_pkg::DW-1:0] mhigh_q;
      logic [2:0] gain_q;
      logic [dwg_pkg::TW-1:0] tmr_q;
      logic [dwg_pkg::DW:0] ramp_q;
      logic [4:0] sidx_q;
      dwg_pkg::dwg_dir_e dir_q;
      logic [dwg_pkg::DW-1:0] code_q;
      logic [dwg_pkg::DW-1:0] sine_code;
      logic restart;
      logic tick;
      logic sel;
      logic [2:0] func;
      logic [3:0] slew;
      logic [dwg_pkg::DW:0] step;
      logic [dwg_pkg::DW:0] lo;
      logic [dwg_pkg::DW:0] hi;
      logic [dwg_pkg::RW-1:0] rd_word;

      assign sel = (addr_i[dwg_pkg::AW-1] == 1'(g));
      assign func = setup_q[dwg_pkg::F_FUNC_LSB +: 3];
      assign slew = setup_q[dwg_pkg::F_SLEW_LSB +: 4];
      assign step = {1'b0, dwg_pkg::code_step_lsb(setup_q[dwg_pkg::F_STEP_LSB +: 3])};
      assign lo = {1'b0, mlow_q};
      assign hi = {1'b0, mhigh_q};
      // Any setup write restarts the pattern cleanly
      assign restart = wr_i && sel && (addr_i[2:0] == dwg_pkg::REG_SETUP[2:0]);
      assign tick = (tmr_q == '0) && (slew != 4'h0) && setup_q[dwg_pkg::F_START_BIT];

      // Setup holds slew, step, function and phase together
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          setup_q <= dwg_pkg::SETUP_RST;
          mlow_q <= dwg_pkg::MLOW_RST[dwg_pkg::DW-1:0];
          mhigh_q <= dwg_pkg::MHIGH_RST[dwg_pkg::DW-1:0];
          gain_q <= '0;
        end
        else if (wr_i && sel)
        begin
          case (addr_i[2:0])
            dwg_pkg::REG_SETUP[2:0]: setup_q <= wdata_i;
            dwg_pkg::REG_MLOW[2:0]: mlow_q <= wdata_i[dwg_pkg::DW-1:0];
            dwg_pkg::REG_MHIGH[2:0]: mhigh_q <= wdata_i[dwg_pkg::DW-1:0];
            dwg_pkg::REG_OUTSET[2:0]: gain_q <= wdata_i[dwg_pkg::F_GAIN_LSB +: 3];
            default: ;
          endcase
        end
      end

      // Step timer reloads with the slew time in cycles
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          tmr_q <= '0;
        else if (restart)
          tmr_q <= dwg_pkg::step_cycles(wdata_i[dwg_pkg::F_SLEW_LSB +: 4]) - 1'b1;
        else if (tmr_q == '0)
          tmr_q <= dwg_pkg::step_cycles(slew) - 1'b1;
        else
          tmr_q <= tmr_q - 1'b1;
      end

      // Ramp engine for triangle and sawtooth modes
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          ramp_q <= '0;
          dir_q <= dwg_pkg::DWG_IDLE;
        end
        else if (restart)
        begin
          ramp_q <= (wdata_i[dwg_pkg::F_FUNC_LSB +: 3] == dwg_pkg::FN_ISAW) ? hi : lo;
          dir_q <= dwg_pkg::DWG_UP;
        end
        else if (tick)
        begin
          case (func)
            dwg_pkg::FN_TRI:
            begin
              if (dir_q == dwg_pkg::DWG_UP)
              begin
                if (ramp_q + step > hi)
                begin
                  ramp_q <= hi;
                  dir_q <= dwg_pkg::DWG_DOWN;
                end
                else
                  ramp_q <= ramp_q + step;
              end
              else
              begin
                if (ramp_q < lo + step)
                begin
                  ramp_q <= lo;
                  dir_q <= dwg_pkg::DWG_UP;
                end
                else
                  ramp_q <= ramp_q - step;
              end
            end
            dwg_pkg::FN_SAW: // Wrap to low after high
              ramp_q <= (ramp_q + step > hi) ? lo : ramp_q + step;
            dwg_pkg::FN_ISAW: // Wrap to high after low
              ramp_q <= (ramp_q < lo + step) ? hi : ramp_q - step;
            default:
              ramp_q <= ramp_q;
          endcase
        end
      end

      // Sine index starts at the selected phase, one point per step
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          sidx_q <= '0;
        else if (restart)
          sidx_q <= 5'(wdata_i[dwg_pkg::F_PHASE_LSB +: 2] * dwg_pkg::PHASE_PTS);
        else if (tick && func == dwg_pkg::FN_SINE)
          sidx_q <= (sidx_q == dwg_pkg::SINE_LAST) ? 5'h00 : sidx_q + 5'h01;
      end

      dwg_sine_rom u_rom (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .idx_i(sidx_q),
        .data_o(sine_code)
      );

      // Sine ignores margins and step; table only
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          code_q <= '0;
        else if (func == dwg_pkg::FN_SINE)
          code_q <= sine_code;
        else
          code_q <= ramp_q[dwg_pkg::DW-1:0];
      end

      assign code_o[g*dwg_pkg::DW +: dwg_pkg::DW] = code_q;
      assign gain_o[g*3 +: 3] = gain_q;

      // One process per channel word keeps each read word single-driven
      always_comb
      begin
        case (addr_i[2:0])
          dwg_pkg::REG_SETUP[2:0]: rd_word = setup_q;
          dwg_pkg::REG_MLOW[2:0]: rd_word = {4'h0, mlow_q};
          dwg_pkg::REG_MHIGH[2:0]: rd_word = {4'h0, mhigh_q};
          dwg_pkg::REG_OUTSET[2:0]: rd_word = {13'h0000, gain_q};
          dwg_pkg::REG_CODE[2:0]: rd_word = {4'h0, code_q};
          default: rd_word = '0;
        endcase
      end
      assign ch_rd[g] = rd_word;
    end
  endgenerate

  always_comb
  begin
    rd_mux = '0;
    for (int i = 0; i < NCH; i++)
      if (addr_i[dwg_pkg::AW-1] == 1'(i))
        rd_mux = ch_rd[i];
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= rd_mux;
  end
endmodule

//--- tb/dwg_stage_model.sv
// Purpose: Output stage stand-in counting channel 0 code updates.
// Assumes: Codes arrive registered on the generator clock.
// Notes: No analog settling modelled; every change counts.
`timescale 1ns/1ps
module dwg_stage_model (
  input wire logic ref_clk_i, // Clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [23:0] code_i, // Channel codes
  output logic [15:0] steps_o // Channel 0 changes seen
);
  logic [11:0] last_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      last_q <= 12'h000;
      steps_o <= 16'h0000;
    end
    else if (code_i[11:0] != last_q)
    begin
      last_q <= code_i[11:0];
      steps_o <= steps_o + 16'h0001;
    end
endmodule

//--- tb/dwg_top_asserts.sv
// Purpose: Port-level checks for the waveform generator.
// Assumes: Channel 0 at word 0, channel 1 at word 8.
// Notes: Margin shadows follow channel 0 writes only.
`timescale 1ns/1ps
module dwg_top_asserts #(
  parameter int NCH = 2
) (
  input wire logic ref_clk_i, // Clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [dwg_pkg::AW-1:0] addr_i, // Word index
  input wire logic [dwg_pkg::RW-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [dwg_pkg::RW-1:0] rdata_o, // Read data
  input wire logic [NCH*dwg_pkg::DW-1:0] code_o, // Codes
  input wire logic [NCH*3-1:0] gain_o // Gains
);
  logic [11:0] lo_q, hi_q, c0_q;
  logic [15:0] hold_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      lo_q <= 12'h000;
      hi_q <= 12'hfff;
      c0_q <= 12'h000;
    end
    else
    begin
      c0_q <= code_o[11:0];
      if (wr_i && addr_i == 4'h1)
        lo_q <= wdata_i[11:0];
      if (wr_i && addr_i == 4'h2)
        hi_q <= wdata_i[11:0];
    end
  // Restart on any write, so a channel 0 restart into a ramp mode never reads as a short step
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
      hold_q <= 16'h0000;
    else if (wr_i || code_o[11:0] != c0_q)
      hold_q <= 16'h0000;
    else if (hold_q != 16'hffff)
      hold_q <= hold_q + 16'h0001;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_out_reset: assert property ($rose(rstn_i) |-> code_o == '0 && gain_o == '0)
    else $error("outputs not clear after reset");
  chk_step_hold: assert property (code_o[11:0] != c0_q && !$past(wr_i) && !$past(wr_i, 2) |-> hold_q >= 16'd498)
    else $error("code step shorter than one step time");
  chk_rd_zero: assert property (rd_i && addr_i[2:0] > 3'h4 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_rd_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  chk_low_read: assert property (rd_i && !wr_i && addr_i == 4'h1 |=> rdata_o == {4'h0, lo_q})
    else $error("low margin readback wrong");
  chk_gain_write: assert property (wr_i && addr_i == 4'hb |=> gain_o[5:3] == $past(wdata_i[2:0]))
    else $error("gain not taken from write");
  // Ramp restart shows on the pins two edges after the write, sine through the table three
  chk_ramp_start: assert property (wr_i && addr_i == 4'h0 && wdata_i[13] && wdata_i[10:9] == 2'b00
    |-> ##2 code_o[11:0] == lo_q)
    else $error("ramp did not restart at low margin");
  chk_inv_start: assert property (wr_i && addr_i == 4'h0 && wdata_i[13] && wdata_i[10:8] == 3'h2
    && wdata_i[3:0] != 4'h0 |-> ##2 code_o[11:0] == hi_q)
    else $error("inverse ramp did not restart at high margin");
  chk_sine_start: assert property (wr_i && addr_i == 4'h8 && wdata_i[13] && wdata_i[10:8] == 3'h4
    && !wdata_i[11] |-> ##3 code_o[23:12] == 12'h800)
    else $error("sine did not start at mid-scale");
endmodule
bind dwg_top dwg_top_asserts #(.NCH(NCH)) u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .code_o(code_o), .gain_o(gain_o));

//--- tb/tb.sv
// Purpose: Self-checking bench for the waveform generator.
// Assumes: Slew code 1 in every stepping test.
// Notes: Codes sampled mid-step to stay clear of edge timing.
`timescale 1ns/1ps
module tb;
  localparam int HOLD = 4000 * 125 / 1000;
  localparam logic [11:0] SIN [24] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f, 12'he66, 12'he2f,
    12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd, 12'h379, 12'h275, 12'h1d1, 12'h19a, 12'h1d1,
    12'h275, 12'h379, 12'h4cd, 12'h658};
  // Triangle dwells one step at each margin, giving twice the sawtooth period
  localparam logic [11:0] RMP [3][5] = '{'{12'h100, 12'h104, 12'h108, 12'h10c, 12'h10c},
    '{12'h100, 12'h104, 12'h108, 12'h10c, 12'h100}, '{12'h10c, 12'h108, 12'h104, 12'h100, 12'h10c}};
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o, steps;
  logic [23:0] code_o;
  logic [5:0] gain_o;
  logic [15:0] exp_q [$];
  logic [31:0] rs = 32'd28;
  logic [31:0] g;
  int fail_count = 0;
  int checked = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  dwg_top #(.NCH(2)) u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .code_o(code_o), .gain_o(gain_o));
  dwg_stage_model u_stage (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .code_i(code_o), .steps_o(steps));
  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic cw(int ch, int n, logic [11:0] e);
    repeat (n) @(posedge ref_clk_i);
    check("code", {4'h0, code_o[ch*12 +: 12]}, {4'h0, e});
  endtask
  task automatic close_out();
    $display("Counts: checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read data is checked in the cycle after the strobe; it holds until the next read
  always @(posedge ref_clk_i)
  begin
    rd_q <= rd_i;
    if (rd_q)
      check("rdata", rdata_o, exp_q.pop_front());
  end
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0fff);
    rd(4'h5, 16'h0000);
    g = xs();
    wr(4'h3, {13'h0, g[2:0]});
    wr(4'hb, {13'h0, g[5:3]});
    rd(4'hb, {13'h0, g[5:3]});
    check("gain", {10'h0, gain_o}, {10'h0, g[5:0]});
    $display("Test registers done");
    wr(4'h1, 16'h0100);
    wr(4'h2, 16'h010c);
    for (int f = 0; f < 3; f++)
    begin
      wr(4'h0, 16'(16'h2031 | (f << 8)));
      cw(0, HOLD / 2, RMP[f][0]);
      rd(4'h4, {4'h0, RMP[f][0]});
      for (int i = 1; i < 5; i++)
        cw(0, HOLD, RMP[f][i]);
      $display("Test ramp %0d done", f);
    end
    wr(4'h0, 16'h2130);
    repeat (4) @(posedge ref_clk_i);
    g = {16'h0, steps};
    cw(0, 3 * HOLD, 12'h100);
    check("steps", steps, g[15:0]);
    $display("Test no slew done");
    wr(4'h9, 16'(xs() & 32'h0fff));
    wr(4'ha, 16'h0fff);
    for (int p = 0; p < 4; p++)
    begin
      wr(4'h8, 16'(16'h2401 | (p << 11)));
      cw(1, HOLD / 2, SIN[6 * p]);
      for (int i = 1; i < 7; i++)
        cw(1, HOLD, SIN[(6 * p + i) % 24]);
    end
    cw(0, 1, 12'h100);
    $display("Test sine done");
    wr(4'h0, 16'h2331);
    cw(0, 3 * HOLD, 12'h100);
    $display("Test reserved function done");
    close_out();
  end
endmodule
